// >>> design/ramp_profiler_pkg.sv
package ramp_profiler_pkg;

	localparam int          CLK_PERIOD_NS    = 8;
	localparam int          TICK_TIME_NS     = 1000000;
	localparam int          TICK_CYCLES      = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int          UNIT_FINE_NS     = 10000000;
	localparam int          UNIT_COARSE_NS   = 100000000;
	localparam logic [7:0]  TICKS_PER_FINE   = 8'(UNIT_FINE_NS / TICK_TIME_NS);
	localparam logic [7:0]  TICKS_PER_COARSE =
		8'(UNIT_COARSE_NS / TICK_TIME_NS);
	localparam int          FRAC_BITS        = 32;

	// Time settings count resolution units; 600.00 s at the fine unit.
	localparam logic [15:0] TIME_MAX     = 16'hEA60;
	localparam logic [15:0] TIME_RESET_1 = 16'h00C8;
	localparam logic [15:0] TIME_RESET_2 = 16'h012C;
	localparam logic [15:0] TIME_RESET_3 = 16'h0190;
	localparam logic [15:0] TIME_RESET_4 = 16'h01F4;

	// Curve rates count 0.1 %; 50.0 % is both the ceiling and the divisor.
	localparam logic [9:0]  RATE_MAX   = 10'h1F4;
	localparam logic [9:0]  RATE_RESET = 10'h000;

	// Parameter store index: bit 3 picks rates, bit 2 picks decel times.
	localparam logic [1:0]  RATE_ACC_START = 2'h0;
	localparam logic [1:0]  RATE_ACC_END   = 2'h1;
	localparam logic [1:0]  RATE_DEC_START = 2'h2;
	localparam logic [1:0]  RATE_DEC_END   = 2'h3;

	localparam logic        BASIS_MAX_SPEED = 1'b0;
	localparam logic        RES_FINE        = 1'b0;

	typedef enum logic {ST_IDLE, ST_RUN} ramp_state_t;

endpackage : ramp_profiler_pkg

// >>> design/accel_decel_ramp_profiler.sv
`timescale 1ns/1ps

module accel_decel_ramp_profiler #(
	parameter int TICK_CYCLES = ramp_profiler_pkg::TICK_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic [15:0] i_target_speed,
	input  wire logic [15:0] i_top_speed_limit,
	input  wire logic        i_ramp_basis_select,
	input  wire logic        i_ramp_time_resolution,
	input  wire logic        i_time_sel_low,
	input  wire logic        i_time_sel_high,
	input  wire logic        i_fast_ramp_override,
	input  wire logic        i_param_wr,
	input  wire logic [3:0]  i_param_sel,
	input  wire logic [15:0] i_param_data,
	output logic      [15:0] o_speed_ref,
	output logic             o_ramping
);

	typedef struct packed {
		ramp_profiler_pkg::ramp_state_t st;
		logic [31:0]       tick_cnt;
		logic [7:0][15:0]  times;
		logic [3:0][9:0]   rates;
		logic [47:0]       pos;
		logic [47:0]       acc;
		logic [47:0]       acc_full;
		logic [47:0]       js;
		logic [47:0]       je;
		logic [15:0]       tgt;
		logic              up;
		logic [1:0]        pair;
		logic [15:0]       spd;
		logic              ramping;
	} ramp_regs_t;

	ramp_regs_t  r_reg;
	ramp_regs_t  r_next;
	logic        tick;
	logic        up;
	logic        restart;
	logic [1:0]  pair;
	logic [15:0] delta;
	logic [15:0] span;
	logic [15:0] tsel;
	logic [7:0]  unit;
	logic [31:0] t_ticks;
	logic [47:0] acc_full;
	logic [47:0] st_s;
	logic [47:0] st_e;
	logic [47:0] js;
	logic [47:0] je;
	logic [9:0]  rs;
	logic [9:0]  re;
	logic [47:0] rem;
	logic [47:0] acc_n;
	logic        brake;

	always_comb begin
		r_next = r_reg;
		tick = (r_reg.tick_cnt == 32'h0);
		r_next.tick_cnt = tick ? 32'(TICK_CYCLES - 1)
			: r_reg.tick_cnt - 32'h1;
		if (i_param_wr) begin
			if (!i_param_sel[3]) begin
				r_next.times[i_param_sel[2:0]] =
					(i_param_data > ramp_profiler_pkg::TIME_MAX)
					? ramp_profiler_pkg::TIME_MAX : i_param_data;
			end else begin
				r_next.rates[i_param_sel[1:0]] =
					(i_param_data > {6'h00, ramp_profiler_pkg::RATE_MAX})
					? ramp_profiler_pkg::RATE_MAX : i_param_data[9:0];
			end
		end
		up = (i_target_speed > r_reg.spd);
		delta = up ? i_target_speed - r_reg.spd : r_reg.spd - i_target_speed;
		pair = {i_time_sel_high, i_time_sel_low};
		tsel = up ? r_reg.times[{1'b0, pair}] : r_reg.times[{1'b1, pair}];
		unit = (i_ramp_time_resolution == ramp_profiler_pkg::RES_FINE)
			? ramp_profiler_pkg::TICKS_PER_FINE
			: ramp_profiler_pkg::TICKS_PER_COARSE;
		t_ticks = 32'(tsel) * 32'(unit);
		span = (i_ramp_basis_select == ramp_profiler_pkg::BASIS_MAX_SPEED)
			? i_top_speed_limit : delta;
		acc_full = (t_ticks == 32'h0) ? 48'h0
			: 48'({span, 32'h0} / 64'(t_ticks));
		if (acc_full == 48'h0) begin
			acc_full = 48'h1;
		end
		rs = up ? r_reg.rates[ramp_profiler_pkg::RATE_ACC_START]
			: r_reg.rates[ramp_profiler_pkg::RATE_DEC_START];
		re = up ? r_reg.rates[ramp_profiler_pkg::RATE_ACC_END]
			: r_reg.rates[ramp_profiler_pkg::RATE_DEC_END];
		st_s = 48'((64'(t_ticks) * 64'(rs))
			/ 64'(ramp_profiler_pkg::RATE_MAX));
		st_e = 48'((64'(t_ticks) * 64'(re))
			/ 64'(ramp_profiler_pkg::RATE_MAX));
		// A zero curve length gives a jerk equal to the full slope.
		js = (st_s == 48'h0) ? acc_full : acc_full / st_s;
		je = (st_e == 48'h0) ? acc_full : acc_full / st_e;
		if (js == 48'h0) begin
			js = 48'h1;
		end
		if (je == 48'h0) begin
			je = 48'h1;
		end
		rem = r_reg.up ? {r_reg.tgt, 32'h0} - r_reg.pos
			: r_reg.pos - {r_reg.tgt, 32'h0};
		// Ramp the slope down once the rest just fits the closing curve;
		// this shortens both curves on small steps with no square root.
		brake = (97'({rem, 1'b0}) * 97'(r_reg.je))
			<= (97'(r_reg.acc) * 97'(r_reg.acc));
		if (brake) begin
			acc_n = (r_reg.acc > r_reg.je) ? r_reg.acc - r_reg.je
				: r_reg.je;
		end else if (r_reg.acc + r_reg.js >= r_reg.acc_full) begin
			acc_n = r_reg.acc_full;
		end else begin
			acc_n = r_reg.acc + r_reg.js;
		end
		restart = tick && (i_target_speed != r_reg.tgt);
		if (restart) begin
			// Restarting from zero slope trades a slight dip for simplicity.
			r_next.tgt = i_target_speed;
			r_next.up = up;
			r_next.pair = pair;
			r_next.acc = 48'h0;
			r_next.acc_full = acc_full;
			r_next.js = js;
			r_next.je = je;
			r_next.st = ramp_profiler_pkg::ST_RUN;
			if (i_fast_ramp_override || t_ticks == 32'h0) begin
				r_next.pos = {i_target_speed, 32'h0};
				r_next.st = ramp_profiler_pkg::ST_IDLE;
			end
		end else if (tick && r_reg.st == ramp_profiler_pkg::ST_RUN) begin
			if (rem <= acc_n) begin
				r_next.pos = {r_reg.tgt, 32'h0};
				r_next.acc = 48'h0;
				r_next.st = ramp_profiler_pkg::ST_IDLE;
			end else begin
				r_next.acc = acc_n;
				r_next.pos = r_reg.up ? r_reg.pos + acc_n
					: r_reg.pos - acc_n;
			end
		end
		r_next.spd = r_next.pos[47:32];
		r_next.ramping = (r_next.st == ramp_profiler_pkg::ST_RUN);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			r_reg <= '0;
			r_reg.st <= ramp_profiler_pkg::ST_IDLE;
			r_reg.times[0] <= ramp_profiler_pkg::TIME_RESET_1;
			r_reg.times[1] <= ramp_profiler_pkg::TIME_RESET_2;
			r_reg.times[2] <= ramp_profiler_pkg::TIME_RESET_3;
			r_reg.times[3] <= ramp_profiler_pkg::TIME_RESET_4;
			r_reg.times[4] <= ramp_profiler_pkg::TIME_RESET_1;
			r_reg.times[5] <= ramp_profiler_pkg::TIME_RESET_2;
			r_reg.times[6] <= ramp_profiler_pkg::TIME_RESET_3;
			r_reg.times[7] <= ramp_profiler_pkg::TIME_RESET_4;
			r_reg.rates <= {4{ramp_profiler_pkg::RATE_RESET}};
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_speed_ref = r_reg.spd;
	assign o_ramping   = r_reg.ramping;

	property p_defaults;
		@(posedge i_clk) disable iff (!i_rstn)
		$past(!i_rstn) |-> (r_reg.times[3] == 16'h01F4
			&& r_reg.times[4] == 16'h00C8 && r_reg.rates == '0);
	endproperty
	a_defaults: assert property (p_defaults)
		else $error("Setting defaults wrong after reset.");

	property p_rate_clamp;
		@(posedge i_clk) disable iff (!i_rstn)
		i_param_wr && i_param_sel[3] && i_param_data > 16'h01F4
		|=> r_reg.rates[$past(i_param_sel[1:0])] == 10'h1F4;
	endproperty
	a_rate_clamp: assert property (p_rate_clamp)
		else $error("Curve rate not clamped to fifty percent.");

	property p_tick_only;
		@(posedge i_clk) disable iff (!i_rstn)
		(r_reg.tick_cnt != 32'h0) |=> $stable(o_speed_ref);
	endproperty
	a_tick_only: assert property (p_tick_only)
		else $error("Speed moved between ticks.");

	property p_no_overshoot;
		@(posedge i_clk) disable iff (!i_rstn)
		r_reg.st == ramp_profiler_pkg::ST_RUN
		|-> (r_reg.up ? o_speed_ref <= r_reg.tgt : o_speed_ref >= r_reg.tgt);
	endproperty
	a_no_overshoot: assert property (p_no_overshoot)
		else $error("Speed passed the target during a ramp.");

	property p_slope_cap;
		@(posedge i_clk) disable iff (!i_rstn)
		r_reg.acc <= r_reg.acc_full;
	endproperty
	a_slope_cap: assert property (p_slope_cap)
		else $error("Slope exceeds the programmed full slope.");

	property p_fast;
		@(posedge i_clk) disable iff (!i_rstn)
		restart && i_fast_ramp_override
		|=> o_speed_ref == $past(i_target_speed) && !o_ramping;
	endproperty
	a_fast: assert property (p_fast)
		else $error("Override did not jump to the target.");

	property p_linear;
		@(posedge i_clk) disable iff (!i_rstn)
		restart && rs == 10'h000 && re == 10'h000
		|=> r_reg.js == r_reg.acc_full && r_reg.je == r_reg.acc_full;
	endproperty
	a_linear: assert property (p_linear)
		else $error("Zero rates did not give a straight ramp.");

	property p_pair;
		@(posedge i_clk) disable iff (!i_rstn)
		restart |=> r_reg.pair == $past({i_time_sel_high, i_time_sel_low});
	endproperty
	a_pair: assert property (p_pair)
		else $error("Time pair does not follow the select terminals.");

	property p_finish;
		@(posedge i_clk) disable iff (!i_rstn)
		$fell(o_ramping) && !$past(restart) |-> o_speed_ref == r_reg.tgt;
	endproperty
	a_finish: assert property (p_finish)
		else $error("Ramp ended away from the target.");

endmodule : accel_decel_ramp_profiler

// >>> testbench/terminal_model.sv
`timescale 1ns/1ps

module terminal_model (
	input  wire logic        i_clk,
	input  wire logic [1:0]  i_pair,
	input  wire logic        i_fast,
	output logic             o_sel_low,
	output logic             o_sel_high,
	output logic             o_fast,
	output logic             o_param_wr,
	output logic      [3:0]  o_param_sel,
	output logic      [15:0] o_param_data
);
	initial begin
		{o_sel_high, o_sel_low, o_fast, o_param_wr} = 4'h0;
		o_param_sel = 4'h0;
		o_param_data = 16'h0000;
	end
	// Terminals move one step after the edge so the sample is never racy.
	always @(posedge i_clk) begin
		#1;
		{o_sel_high, o_sel_low} <= i_pair;
		o_fast <= i_fast;
	end
	task automatic wr(input logic [3:0] sel, input logic [15:0] data);
		@(posedge i_clk);
		#1;
		o_param_wr = 1'b1;
		o_param_sel = sel;
		o_param_data = data;
		@(posedge i_clk);
		#1;
		o_param_wr = 1'b0;
	endtask : wr
endmodule : terminal_model

// >>> testbench/accel_decel_ramp_profiler_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR %0t: got %0h expected %0h", $time, (a), (b)); end end

module accel_decel_ramp_profiler_tb_top;
	localparam int TC = 4;
	typedef struct {logic [15:0] spd; int ticks; int tol;} note_t;
	logic        i_clk = 1'b0;
	logic        i_rstn = 1'b0;
	logic [15:0] tgt = 16'h0000;
	logic [15:0] top = 16'h0064;
	logic        basis = 1'b0;
	logic        res = 1'b0;
	logic [1:0]  pair = 2'h0;
	logic        fast = 1'b0;
	logic        sel_low, sel_high, fast_t, wr;
	logic [3:0]  psel;
	logic [15:0] pdata, o_speed_ref;
	logic        o_ramping, ramp_d;
	int          err_count = 0, cmp_count = 0, cycles = 0, run_len = 0, p;
	int          dt;
	note_t       q[$];
	note_t       n;

	always #4 i_clk = ~i_clk;

	terminal_model terminal_model_inst (.i_clk(i_clk), .i_pair(pair),
		.i_fast(fast), .o_sel_low(sel_low), .o_sel_high(sel_high),
		.o_fast(fast_t), .o_param_wr(wr), .o_param_sel(psel),
		.o_param_data(pdata));

	accel_decel_ramp_profiler #(.TICK_CYCLES(TC))
		accel_decel_ramp_profiler_inst (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_target_speed(tgt), .i_top_speed_limit(top),
		.i_ramp_basis_select(basis), .i_ramp_time_resolution(res),
		.i_time_sel_low(sel_low), .i_time_sel_high(sel_high),
		.i_fast_ramp_override(fast_t), .i_param_wr(wr),
		.i_param_sel(psel), .i_param_data(pdata),
		.o_speed_ref(o_speed_ref), .o_ramping(o_ramping));

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			stop_test();
		end
	end

	// Ramp length is judged in ticks, with a tolerance for curved profiles.
	always @(negedge i_clk) begin
		if (o_ramping === 1'b1 && ramp_d !== 1'b1) run_len = 0;
		if (o_ramping === 1'b1) run_len++;
		if (ramp_d === 1'b1 && o_ramping === 1'b0 && q.size() > 0) begin
			n = q.pop_front();
			dt = run_len / TC - n.ticks;
			`CHK(o_speed_ref, n.spd)
			`CHK((dt <= n.tol && -dt <= n.tol), 1'b1)
		end
		ramp_d = o_ramping;
	end

	task automatic ramp(input logic [15:0] t, input int tk, input int tol);
		int k;
		q.push_back('{t, tk, tol});
		@(posedge i_clk);
		#1;
		tgt = t;
		for (k = 0; k < 9000 && q.size() > 0; k++) @(posedge i_clk);
		#1;
	endtask : ramp

	initial begin
		void'($urandom(32'h64ff07bd));
		repeat (5) @(posedge i_clk);
		#1;
		i_rstn = 1'b1;
		`CHK(o_speed_ref, 16'h0000)
		`CHK(o_ramping, 1'b0)
		ramp(16'h0064, 2000, 2);
		ramp(16'h0000, 2000, 2);
		for (p = 0; p < 4; p++) begin
			terminal_model_inst.wr(4'(p), 16'(p + 1));
			terminal_model_inst.wr(4'(p + 4), 16'(2 * p + 2));
			pair = 2'(p);
			ramp(16'h0064, 10 * (p + 1), 1);
			ramp(16'h0000, 20 * (p + 1), 1);
		end
		pair = 2'h0;
		ramp(16'h0032, 5, 1);
		ramp(16'h0000, 10, 1);
		basis = 1'b1;
		ramp(16'(1 + $urandom % 100), 10, 1);
		ramp(16'h0000, 20, 1);
		basis = 1'b0;
		res = 1'b1;
		ramp(16'h0064, 100, 2);
		ramp(16'h0000, 200, 2);
		res = 1'b0;
		for (p = 500; p > 0; p -= 250) begin
			terminal_model_inst.wr(4'h8, 16'(p));
			terminal_model_inst.wr(4'h9, 16'(p));
			terminal_model_inst.wr(4'hA, 16'(p));
			terminal_model_inst.wr(4'hB, 16'(p));
			ramp(16'h0064, 10 + p / 50, 3);
			ramp(16'h0000, 20 + p / 25, 4);
		end
		// Steps below both curve spans skip the straight part.
		ramp(16'h001E, 8, 2);
		ramp(16'h0000, 15, 2);
		// An over-range rate must be clamped before it is cleared again.
		terminal_model_inst.wr(4'h8, 16'hFFFF);
		for (p = 8; p < 12; p++) terminal_model_inst.wr(4'(p), 16'h0000);
		// A fresh target mid-ramp must turn the ramp round, not finish it.
		q.push_back('{16'h0000, 15, 2});
		tgt = 16'h0064;
		repeat (6 * TC) @(posedge i_clk);
		#1;
		tgt = 16'h0000;
		for (p = 0; p < 400 && q.size() > 0; p++) @(posedge i_clk);
		#1;
		`CHK(q.size(), 0)
		fast = 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		tgt = 16'h0064;
		for (p = 0; p < 12 && o_speed_ref !== 16'h0064; p++) begin
			@(posedge i_clk);
			#1;
		end
		`CHK(o_speed_ref, 16'h0064)
		`CHK(o_ramping, 1'b0)
		stop_test();
	end
endmodule : accel_decel_ramp_profiler_tb_top
